// File: hdl/alu_io_map.vh
// Register offsets, field positions, reset values and codes of the datapath block
`ifndef ALU_IO_MAP_VH
`define ALU_IO_MAP_VH

// ----------------------------------------
// Bus register byte offsets
// ----------------------------------------
`define OFS_CMD       8'h00
`define OFS_OPD       8'h04
`define OFS_OPS       8'h08
`define OFS_STATUS    8'h0C
`define OFS_RESULT    8'h10
`define OFS_IO_CMD    8'h14
`define OFS_IO_ADDR   8'h18
`define OFS_IO_DATA   8'h1C

// ----------------------------------------
// Status register bits
// ----------------------------------------
`define ST_C          0
`define ST_Z          1
`define ST_N          2
`define ST_V          3
`define ST_S          4
`define ST_H          5
`define ST_BUSY       8
`define STATUS_RST    6'h00

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_ADD        4'h0
`define OP_ADC        4'h1
`define OP_SUB        4'h2
`define OP_SBC        4'h3
`define OP_IMMEDIATE_DIFFERENCE       4'h4
`define OP_IMMEDIATE_DIFFERENCE_WITH_BORROW       4'h5
`define OP_AND        4'h6
`define OP_CONJUNCTION_IMMEDIATE       4'h7
`define OP_OR         4'h8
`define OP_ORI        4'h9
`define OP_EOR        4'hA
`define OP_COM        4'hB
`define OP_NEG        4'hC
`define OP_SETMASK    4'hD
`define OP_WADD       4'hE
`define OP_WSUB       4'hF

// ----------------------------------------
// Cycle counts
// ----------------------------------------
`define CYC_BYTE      2'h1
`define CYC_WORD      2'h2

// ----------------------------------------
// I/O access kinds and address ranges
// ----------------------------------------
`define IO_IN         3'h0
`define IO_OUT        3'h1
`define IO_LOAD       3'h2
`define IO_STORE      3'h3
`define IO_BSET       3'h4
`define IO_BCLR       3'h5
`define IO_SKIP_ONE   3'h6
`define IO_SKIP_ZERO  3'h7
`define IO_BIT_TOP    8'h1F
`define IO_DIRECT_TOP 8'h3F
`define IO_DATA_OFS   8'h20
`define IO_RSV_LO     8'h2C
`define IO_RSV_HI     8'h34
`define IO_FLAG_BASE  8'h35
`define IO_FLAG_CNT   4

`endif

// File: hdl/byte_alu.v
// Combinational 8-bit arithmetic and logic unit with flag outputs
`timescale 1ns/1ps

module byte_alu (
	input  wire [3:0] op,
	input  wire [7:0] a,
	input  wire [7:0] b,
	input  wire       cin,
	output reg  [7:0] res,
	output reg  [5:0] flg,
	output reg  [5:0] upd
);

`include "alu_io_map.vh"

reg [8:0] sum;
reg       sub;

// ----------------------------------------
// Result and flags per operation
// ----------------------------------------
always @* begin
	sum = 9'h000;
	sub = 1'b0;
	flg = 6'h00;
	upd = 6'h00;
	case (op)
		`OP_ADD, `OP_ADC: begin
			sum = {1'b0, a} + {1'b0, b} + {8'h00, (op == `OP_ADC) & cin}; // see [RL1]
		end
		`OP_SUB, `OP_IMMEDIATE_DIFFERENCE: begin
			sub = 1'b1;
			sum = {1'b0, a} - {1'b0, b}; // see [RL3] see [RL4]
		end
		`OP_NEG: begin
			sub = 1'b1;
			// Negation works on the destination alone, the source is ignored
			sum = 9'h000 - {1'b0, a}; // see [RL9]
		end
		`OP_SBC, `OP_IMMEDIATE_DIFFERENCE_WITH_BORROW: begin
			sub = 1'b1;
			sum = {1'b0, a} - {1'b0, b} - {8'h00, cin}; // see [RL3] see [RL4]
		end
		`OP_AND, `OP_CONJUNCTION_IMMEDIATE: sum = {1'b0, a & b}; // see [RL6]
		`OP_OR, `OP_ORI, `OP_SETMASK: sum = {1'b0, a | b}; // see [RL6] see [RL7]
		`OP_EOR: sum = {1'b0, a ^ b}; // see [RL6]
		`OP_COM: sum = {1'b0, 8'hFF - a}; // see [RL8]
		default: sum = 9'h000;
	endcase
	res = sum[7:0];
	flg[`ST_Z] = (sum[7:0] == 8'h00);
	flg[`ST_N] = sum[7];
	// Add carry, overflow and half carry follow operand and result bits 7 and 3; subtract and negate take carry from the raw borrow out
	case (op)
		`OP_ADD, `OP_ADC: begin
			flg[`ST_C] = a[7] & b[7] | b[7] & ~res[7] | ~res[7] & a[7];
			flg[`ST_H] = a[3] & b[3] | b[3] & ~res[3] | ~res[3] & a[3];
			flg[`ST_V] = a[7] & b[7] & ~res[7] | ~a[7] & ~b[7] & res[7];
			upd = 6'h2F; // see [RL1]
		end
		`OP_SUB, `OP_IMMEDIATE_DIFFERENCE, `OP_SBC, `OP_IMMEDIATE_DIFFERENCE_WITH_BORROW, `OP_NEG: begin
			flg[`ST_C] = sum[8];
			flg[`ST_H] = sub & ((op == `OP_NEG) ? (a[3] | res[3]) :
				(~a[3] & b[3] | b[3] & res[3] | res[3] & ~a[3]));
			flg[`ST_V] = (op == `OP_NEG) ? (res == 8'h80) :
				(a[7] & ~b[7] & ~res[7] | ~a[7] & b[7] & res[7]);
			upd = 6'h2F; // see [RL3] see [RL4] see [RL9]
		end
		`OP_COM: begin
			flg[`ST_C] = 1'b1;
			upd = 6'h0F; // see [RL8]
		end
		`OP_AND, `OP_CONJUNCTION_IMMEDIATE, `OP_OR, `OP_ORI, `OP_EOR, `OP_SETMASK: begin
			upd = 6'h0E; // see [RL6] see [RL7]
		end
		default: upd = 6'h00;
	endcase
end

endmodule

// File: hdl/alu_io_core.v
// Arithmetic datapath and I/O space access block behind an AHB-Lite slave
//
// How it works
// [RL1] Register add stores d+s; carry variant adds C; Z,C,N,V,H; one cycle.
// [RL2] Word add-immediate adds constant to 16-bit pair; Z,C,N,V,S; two cycles.
// [RL3] Register subtract stores d-s; borrow variant subtracts C; Z,C,N,V,H; one cycle.
// [RL4] Immediate subtract, with or without borrow; Z,C,N,V,H; one cycle.
// [RL5] Word subtract-immediate on 16-bit pair; Z,C,N,V,S; two cycles.
// [RL6] And, or, xor with register or constant; only Z,N,V; one cycle.
// [RL7] Set-bits-by-mask equals or with immediate; Z,N,V; one cycle.
// [RL8] Bit inversion gives 0xFF minus value; Z,C,N,V; one cycle.
// [RL9] Arithmetic inverse gives zero minus value; Z,C,N,V,H; one cycle.
// [RL10] Bit set, clear and skip work on I/O 0x00..0x1F only.
// [RL11] Some status flags clear on writing one; zero leaves them.
// [RL12] Bit set or clear rewrite the whole register, clearing set flags.
// [RL13] Direct I/O uses 0x00..0x3F; data space reaches them at plus 0x20.
// [RL14] Extended range 0x60..0xFF only through data-space load and store.
// [RL15] Software writes zero to reserved bits, never writes reserved addresses.
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps

module alu_io_core (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire [31:0] flag_event
);

`include "alu_io_map.vh"

// ----------------------------------------
// Reset release
// ----------------------------------------
reg        rst_meta_q;
reg        rst_sync_q;

// Async assert, clocked release through two stages
// Release on an edge so no flop leaves reset a cycle after its neighbours
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		rst_meta_q <= 1'b0;
		rst_sync_q <= 1'b0;
	end else begin
		rst_meta_q <= 1'b1;
		rst_sync_q <= rst_meta_q;
	end
end

// ----------------------------------------
// Bus slave
// ----------------------------------------
// Map: 0x00 op code, a write starts the ALU
//      0x04 d operand, 0x08 source and constant
//      0x0C flags, bit 8 busy read-only
//      0x10 result
//      0x14 I/O access kind and bit, a write starts it
//      0x18 I/O or data address
//      0x1C I/O data, bit 8 skip, bit 9 refused
// Unmapped offsets read zero; writes to them vanish
reg        wr_pend_q;
reg  [7:0] wr_addr_q;
wire       addr_phase;
wire       wr_cmd;
wire       wr_io_cmd;

assign hreadyout  = 1'b1;
assign hresp      = 1'b0;
assign addr_phase = hsel & htrans[1] & hready;
assign wr_cmd     = wr_pend_q & (wr_addr_q == `OFS_CMD);
assign wr_io_cmd  = wr_pend_q & (wr_addr_q == `OFS_IO_CMD);

// Write address held over to the data phase
always @(posedge clk or negedge rst_sync_q) begin
	if (!rst_sync_q) begin
		wr_pend_q <= 1'b0;
		wr_addr_q <= 8'h00;
	end else begin
		wr_pend_q <= addr_phase & hwrite;
		wr_addr_q <= haddr;
	end
end

// ----------------------------------------
// Operand, status and result registers
// ----------------------------------------
// Byte ops commit one edge after the launch, word ops two;
// busy covers the whole span so software can poll it
reg  [3:0]  op_q;
reg  [15:0] opd_q;
reg  [15:0] ops_q;
reg  [5:0]  st_q;
reg  [15:0] result_q;
reg         busy_q;
reg  [1:0]  cnt_q;
wire [7:0]  alu_res;
wire [5:0]  alu_flg;
wire [5:0]  alu_upd;
wire        imm_op;
wire        word_op;
wire [16:0] wsum;
reg  [5:0]  wflg;

assign imm_op  = (op_q == `OP_IMMEDIATE_DIFFERENCE) | (op_q == `OP_IMMEDIATE_DIFFERENCE_WITH_BORROW) | (op_q == `OP_CONJUNCTION_IMMEDIATE) |
		 (op_q == `OP_ORI) | (op_q == `OP_SETMASK);
assign word_op = (op_q == `OP_WADD) | (op_q == `OP_WSUB);

byte_alu u_alu (
	.op  (op_q),
	.a   (opd_q[7:0]),
	.b   (imm_op ? ops_q[15:8] : ops_q[7:0]),
	.cin (st_q[`ST_C]),
	.res (alu_res),
	.flg (alu_flg),
	.upd (alu_upd)
);

// Word arithmetic on the pair, constant limited to six bits
assign wsum = (op_q == `OP_WADD) ? ({1'b0, opd_q} + {11'h000, ops_q[13:8]}) : // see [RL2]
			({1'b0, opd_q} - {11'h000, ops_q[13:8]}); // see [RL5]

// Word zero and carry from the whole sum, sign and overflow from the high byte sign before and after
always @* begin
	wflg = 6'h00;
	wflg[`ST_Z] = (wsum[15:0] == 16'h0000);
	wflg[`ST_N] = wsum[15];
	wflg[`ST_C] = wsum[16];
	if (op_q == `OP_WADD) begin
		wflg[`ST_V] = ~opd_q[15] & wsum[15]; // see [RL2]
	end else begin
		wflg[`ST_V] = opd_q[15] & ~wsum[15]; // see [RL5]
	end
	wflg[`ST_S] = wflg[`ST_N] ^ wflg[`ST_V];
end

// Launch, count down, then commit result and flags
always @(posedge clk or negedge rst_sync_q) begin
	if (!rst_sync_q) begin
		op_q     <= `OP_ADD;
		opd_q    <= 16'h0000;
		ops_q    <= 16'h0000;
		st_q     <= `STATUS_RST;
		result_q <= 16'h0000;
		busy_q   <= 1'b0;
		cnt_q    <= 2'h0;
	end else if (busy_q) begin
		// Writes while busy are dropped so the operands stay stable
		cnt_q <= cnt_q - 2'h1;
		if (cnt_q == 2'h1) begin
			busy_q <= 1'b0;
			if (word_op) begin
				result_q <= wsum[15:0];
				st_q     <= (st_q & 6'h20) | (wflg & 6'h1F); // see [RL2] see [RL5]
			end else begin
				result_q <= {8'h00, alu_res};
				st_q     <= (st_q & ~alu_upd) | (alu_flg & alu_upd); // see [RL1] see [RL6]
			end
		end
	end else if (wr_pend_q) begin
		case (wr_addr_q)
			`OFS_CMD: begin
				op_q   <= hwdata[3:0];
				busy_q <= 1'b1;
				// Word forms hold the block one more cycle
				cnt_q  <= (hwdata[3:0] == `OP_WADD || hwdata[3:0] == `OP_WSUB) ?
					  `CYC_WORD : `CYC_BYTE; // see [RL2] see [RL5] see [RL1]
			end
			`OFS_OPD:    opd_q <= hwdata[15:0];
			`OFS_OPS:    ops_q <= hwdata[15:0];
			`OFS_STATUS: st_q  <= hwdata[5:0];
			default: ;
		endcase
	end
end

// ----------------------------------------
// I/O space
// ----------------------------------------
// Bit kinds reach the low 32 I/O bytes, direct in and out the low 64,
// data-space kinds everything from 0x20 upward
reg  [2:0]  io_kind_q;
reg  [2:0]  io_bit_q;
reg  [7:0]  io_addr_q;
reg  [7:0]  io_data_q;
reg         io_skip_q;
reg         io_refused_q;
reg         busy_io_q;
reg  [7:0]  io_mem [0:255];
reg  [7:0]  flag_q [0:`IO_FLAG_CNT-1];
reg  [7:0]  da;
reg         ok;
reg         is_wr;
reg  [7:0]  rd_val;
reg  [7:0]  wr_val;
reg  [7:0]  bit_mask;
wire        io_go;
wire        io_write;
wire        is_flag;
wire [7:0]  flag_idx;
wire        in_rsv;
wire        any_busy;

// Data-space address of the access and whether it is allowed
always @* begin
	da       = io_addr_q;
	ok       = 1'b0;
	is_wr    = 1'b0;
	bit_mask = 8'h01 << io_bit_q;
	case (io_kind_q)
		`IO_IN, `IO_OUT: begin
			da    = io_addr_q + `IO_DATA_OFS; // see [RL13]
			ok    = (io_addr_q <= `IO_DIRECT_TOP); // see [RL13] see [RL14]
			is_wr = (io_kind_q == `IO_OUT);
		end
		`IO_LOAD, `IO_STORE: begin
			ok    = (io_addr_q >= `IO_DATA_OFS); // see [RL14]
			is_wr = (io_kind_q == `IO_STORE);
		end
		`IO_BSET, `IO_BCLR, `IO_SKIP_ONE, `IO_SKIP_ZERO: begin
			da    = io_addr_q + `IO_DATA_OFS;
			ok    = (io_addr_q <= `IO_BIT_TOP); // see [RL10]
			is_wr = (io_kind_q == `IO_BSET) | (io_kind_q == `IO_BCLR);
		end
		default: ok = 1'b0;
	endcase
end

assign flag_idx = da - `IO_FLAG_BASE;
assign is_flag  = (da >= `IO_FLAG_BASE) && (flag_idx < `IO_FLAG_CNT);

// Read value, then the byte that a write puts back
always @* begin
	rd_val = is_flag ? flag_q[flag_idx[1:0]] : io_mem[da];
	case (io_kind_q)
		`IO_BSET: wr_val = rd_val | bit_mask; // see [RL12]
		`IO_BCLR: wr_val = rd_val & ~bit_mask; // see [RL12]
		default:  wr_val = io_data_q;
	endcase
end

// Reserved data addresses swallow stores rather than corrupt storage
assign in_rsv   = (da >= `IO_RSV_LO) && (da <= `IO_RSV_HI);
assign io_go    = busy_io_q;
assign io_write = io_go & ok & is_wr & ~in_rsv; // see [RL15]
assign any_busy = busy_q | busy_io_q;

// ----------------------------------------
// I/O access sequencing
// ----------------------------------------
// Access register writes and one-cycle execution
always @(posedge clk or negedge rst_sync_q) begin
	if (!rst_sync_q) begin
		io_kind_q    <= `IO_IN;
		io_bit_q     <= 3'h0;
		io_addr_q    <= 8'h00;
		io_data_q    <= 8'h00;
		io_skip_q    <= 1'b0;
		io_refused_q <= 1'b0;
		busy_io_q    <= 1'b0;
	end else if (busy_io_q) begin
		busy_io_q    <= 1'b0;
		io_refused_q <= ~ok;
		if (ok && !is_wr) begin
			io_data_q <= rd_val;
		end
		if (io_kind_q == `IO_SKIP_ONE) begin
			io_skip_q <= ok & |(rd_val & bit_mask); // see [RL10]
		end else if (io_kind_q == `IO_SKIP_ZERO) begin
			io_skip_q <= ok & ~|(rd_val & bit_mask); // see [RL10]
		end else begin
			io_skip_q <= 1'b0;
		end
	end else if (wr_pend_q) begin
		case (wr_addr_q)
			`OFS_IO_CMD: begin
				io_kind_q <= hwdata[2:0];
				io_bit_q  <= hwdata[10:8];
				busy_io_q <= 1'b1;
			end
			`OFS_IO_ADDR: io_addr_q <= hwdata[7:0];
			`OFS_IO_DATA: io_data_q <= hwdata[7:0];
			default: ;
		endcase
	end
end

// ----------------------------------------
// I/O storage
// ----------------------------------------
// Plain I/O bytes, no reset on the storage array
always @(posedge clk) begin
	if (io_write && !is_flag) begin
		io_mem[da] <= wr_val;
	end
end

// ----------------------------------------
// Flag registers
// ----------------------------------------
// Write-one-to-clear flag registers, a new event beats a clear
// Flags sit at I/O 0x15 upward, data space 0x35 upward
genvar gi;
generate
	for (gi = 0; gi < `IO_FLAG_CNT; gi = gi + 1) begin : g_flag
		wire [7:0] clr;
		assign clr = (io_write && is_flag && flag_idx == gi) ? wr_val : 8'h00;
		always @(posedge clk or negedge rst_sync_q) begin
			if (!rst_sync_q) begin
				flag_q[gi] <= 8'h00;
			end else begin
				flag_q[gi] <= (flag_q[gi] & ~clr) | flag_event[gi*8 +: 8]; // see [RL11]
			end
		end
	end
endgenerate

// ----------------------------------------
// Read data, captured in the address phase
// ----------------------------------------
// Loading at the address edge keeps the data phase free of wait states
always @(posedge clk or negedge rst_sync_q) begin
	if (!rst_sync_q) begin
		hrdata <= 32'h00000000;
	end else if (addr_phase && !hwrite) begin
		case (haddr)
			`OFS_CMD:     hrdata <= {28'h0000000, op_q};
			`OFS_OPD:     hrdata <= {16'h0000, opd_q};
			`OFS_OPS:     hrdata <= {16'h0000, ops_q};
			`OFS_STATUS:  hrdata <= {23'h000000, any_busy, 2'h0, st_q};
			`OFS_RESULT:  hrdata <= {16'h0000, result_q};
			`OFS_IO_CMD:  hrdata <= {21'h000000, io_bit_q, 5'h00, io_kind_q};
			`OFS_IO_ADDR: hrdata <= {24'h000000, io_addr_q};
			`OFS_IO_DATA: hrdata <= {22'h000000, io_refused_q, io_skip_q, io_data_q};
			default:      hrdata <= 32'h00000000;
		endcase
	end
end

endmodule

// File: verif/alu_io_props.sv
// Port checker of the datapath block bus slave
`timescale 1ns/1ps
`include "alu_io_map.vh"

module alu_io_props (
	input wire        clk,
	input wire        rst_n,
	input wire        hsel,
	input wire [7:0]  haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [2:0]  hsize,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] flag_event
);
	// ----------------------------------------
	// Own busy model
	// ----------------------------------------
	wire       take = hsel && htrans[1] && hready;
	wire       rd_take = take && !hwrite;
	reg        aw_cmd_q;
	reg        aw_io_q;
	reg        io_b_q;
	reg  [1:0] alu_b_q;
	wire       busy_m = (alu_b_q != 2'h0) || io_b_q;

	// Word ops stay busy one edge longer than byte ops
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_cmd_q <= 1'b0;
			aw_io_q <= 1'b0;
			io_b_q <= 1'b0;
			alu_b_q <= 2'h0;
		end else begin
			aw_cmd_q <= take && hwrite && (haddr == `OFS_CMD);
			aw_io_q <= take && hwrite && (haddr == `OFS_IO_CMD);
			io_b_q <= aw_io_q && !io_b_q;
			if (aw_cmd_q && alu_b_q == 2'h0)
				alu_b_q <= (hwdata[3:0] >= `OP_WADD) ? `CYC_WORD : `CYC_BYTE;
			else if (alu_b_q != 2'h0)
				alu_b_q <= alu_b_q - 2'h1;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ready_high: assert property (hreadyout)
		else $error("ready dropped");
	a_resp_okay: assert property (!hresp)
		else $error("error response seen");
	a_busy_track: assert property (
		rd_take && haddr == `OFS_STATUS |=> hrdata[`ST_BUSY] == $past(busy_m))
		else $error("busy bit timing wrong");
	a_unmapped_zero: assert property (rd_take && haddr > `OFS_IO_DATA |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_result_width: assert property (
		rd_take && haddr == `OFS_RESULT |=> hrdata[31:16] == 16'h0)
		else $error("result upper bits set");
	a_status_spare: assert property (
		rd_take && haddr == `OFS_STATUS |=> hrdata[31:9] == 23'h0 && hrdata[7:6] == 2'h0)
		else $error("status spare bits set");
	a_iodata_width: assert property (
		rd_take && haddr == `OFS_IO_DATA |=> hrdata[31:10] == 22'h0)
		else $error("io data upper bits set");
	a_reset_quiet: assert property ($rose(rst_n) |-> hrdata == 32'h0 ##1 hrdata == 32'h0)
		else $error("read data moved after reset");
endmodule

bind alu_io_core alu_io_props u_props (.clk(clk), .rst_n(rst_n), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.flag_event(flag_event));

// File: verif/test_alu_io_core.sv
// Self-checking bench of the datapath block over its bus slave
`timescale 1ns/1ps
`include "alu_io_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end

module test_alu_io_core;
	reg         clk;
	reg         rst_n;
	reg         hsel;
	reg         hwrite;
	reg  [7:0]  haddr;
	reg  [1:0]  htrans;
	reg  [31:0] hwdata;
	reg  [31:0] flag_event;
	reg  [31:0] rd;
	wire [31:0] hrdata;
	wire        hreadyout;
	wire        hresp;
	int         mismatches;
	int         n_checks;
	int         cyc;

	// Slave ready is the bus ready; word size only
	alu_io_core dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .flag_event(flag_event));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Address phase held until ready, then data phase held until ready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// Poll busy, bounded so a stuck flag cannot hang the run
	task automatic wait_idle;
		for (int i = 0; i < 20; i++) begin
			bus(1'b0, `OFS_STATUS, 32'h0);
			if (rd[`ST_BUSY] === 1'b0) break;
		end
		`CHK("busy", 1'b0, rd[`ST_BUSY])
	endtask

	task automatic one(input logic [3:0] op, input logic [15:0] d, k,
		input logic [5:0] s0, input logic [15:0] r, input logic [5:0] s);
		bus(1'b1, `OFS_OPD, {16'h0, d});
		bus(1'b1, `OFS_OPS, {16'h0, k});
		bus(1'b1, `OFS_STATUS, {26'h0, s0});
		bus(1'b1, `OFS_CMD, {28'h0, op});
		wait_idle;
		bus(1'b0, `OFS_RESULT, 32'h0);
		`CHK("result", {16'h0, r}, rd)
		bus(1'b0, `OFS_STATUS, 32'h0);
		`CHK("flags", s, rd[5:0])
	endtask

	// Unused bits go out as zero; reserved I/O is never written
	task automatic io(input logic [2:0] kind, b, input logic [7:0] a, v);
		bus(1'b1, `OFS_IO_ADDR, {24'h0, a});
		bus(1'b1, `OFS_IO_DATA, {24'h0, v});
		bus(1'b1, `OFS_IO_CMD, {21'h0, b, 5'h0, kind});
		wait_idle;
		bus(1'b0, `OFS_IO_DATA, 32'h0);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Boundary operands; preset flags show which ones an op leaves alone
	task automatic alu_ops;
		one(`OP_ADD, 16'h000F, 16'h0001, 6'h10, 16'h0010, 6'h30);
		one(`OP_ADC, 16'h007F, 16'h0000, 6'h01, 16'h0080, 6'h2C);
		one(`OP_SUB, 16'h0000, 16'h0001, 6'h00, 16'h00FF, 6'h25);
		one(`OP_SBC, 16'h0080, 16'h0000, 6'h01, 16'h007F, 6'h28);
		one(`OP_IMMEDIATE_DIFFERENCE, 16'h0005, 16'h0500, 6'h2D, 16'h0000, 6'h02);
		one(`OP_IMMEDIATE_DIFFERENCE_WITH_BORROW, 16'h0010, 16'h0000, 6'h01, 16'h000F, 6'h20);
		one(`OP_AND, 16'h00F0, 16'h008F, 6'h39, 16'h0080, 6'h35);
		one(`OP_CONJUNCTION_IMMEDIATE, 16'h000F, 16'hF000, 6'h00, 16'h0000, 6'h02);
		one(`OP_OR, 16'h0001, 16'h0080, 6'h00, 16'h0081, 6'h04);
		one(`OP_ORI, 16'h0000, 16'h0000, 6'h21, 16'h0000, 6'h23);
		one(`OP_EOR, 16'h00AA, 16'h00AA, 6'h00, 16'h0000, 6'h02);
		one(`OP_COM, 16'h007F, 16'h0000, 6'h20, 16'h0080, 6'h25);
		one(`OP_NEG, 16'h0080, 16'h0000, 6'h20, 16'h0080, 6'h0D);
		one(`OP_SETMASK, 16'h0000, 16'h8000, 6'h00, 16'h0080, 6'h04);
		one(`OP_WADD, 16'hFFFF, 16'h0100, 6'h20, 16'h0000, 6'h23);
		one(`OP_WSUB, 16'h8000, 16'h0100, 6'h00, 16'h7FFF, 6'h18);
	endtask

	// Readback of the last word operation and of an unmapped offset
	task automatic map_reads;
		bus(1'b0, `OFS_OPD, 32'h0);
		`CHK("opd", 32'h00008000, rd)
		bus(1'b0, `OFS_CMD, 32'h0);
		`CHK("cmd", {28'h0, `OP_WSUB}, rd)
		bus(1'b0, 8'h20, 32'h0);
		`CHK("unmapped", 32'h0, rd)
	endtask

	task automatic io_ops;
		io(`IO_OUT, 3'h0, 8'h05, 8'hA5);
		io(`IO_LOAD, 3'h0, 8'h25, 8'h00);
		`CHK("load", 10'h0A5, rd[9:0])
		io(`IO_STORE, 3'h0, 8'h2A, 8'h3C);
		io(`IO_IN, 3'h0, 8'h0A, 8'h00);
		`CHK("in", 10'h03C, rd[9:0])
		io(`IO_IN, 3'h0, 8'h40, 8'h00);
		`CHK("in refused", 1'b1, rd[9])
		io(`IO_STORE, 3'h0, 8'h60, 8'h5A);
		io(`IO_LOAD, 3'h0, 8'h60, 8'h00);
		`CHK("extended", 10'h05A, rd[9:0])
		io(`IO_OUT, 3'h0, 8'h02, 8'h00);
		io(`IO_BSET, 3'h3, 8'h02, 8'h00);
		io(`IO_SKIP_ONE, 3'h3, 8'h02, 8'h00);
		`CHK("skip one", 2'h1, rd[9:8])
		io(`IO_SKIP_ZERO, 3'h3, 8'h02, 8'h00);
		`CHK("skip zero", 2'h0, rd[9:8])
		io(`IO_BCLR, 3'h3, 8'h02, 8'h00);
		io(`IO_IN, 3'h0, 8'h02, 8'h00);
		`CHK("bit clear", 10'h000, rd[9:0])
		io(`IO_BSET, 3'h0, 8'h20, 8'h00);
		`CHK("bit refused", 2'h2, rd[9:8])
		// Flag pulse for one edge raises three flags of the first flag byte
		flag_event <= 32'h00000007;
		@(posedge clk);
		flag_event <= 32'h0;
		io(`IO_OUT, 3'h0, 8'h15, 8'h01);
		io(`IO_IN, 3'h0, 8'h15, 8'h00);
		`CHK("one clears", 10'h006, rd[9:0])
		io(`IO_BSET, 3'h7, 8'h15, 8'h00);
		io(`IO_IN, 3'h0, 8'h15, 8'h00);
		`CHK("set clears all", 10'h000, rd[9:0])
		bus(1'b0, `OFS_IO_ADDR, 32'h0);
		`CHK("io addr", 32'h00000015, rd)
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			final_report;
		end
	end

	initial begin
		{rst_n, hsel, hwrite, haddr, htrans, hwdata, flag_event} = '0;
		mismatches = 0;
		n_checks = 0;
		cyc = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		alu_ops;
		map_reads;
		io_ops;
		final_report;
	end
endmodule
